/* File: logic/cdri_pkg.sv */
package cdri_pkg;
  localparam int          CDRI_NUM_WATCH  = 2;
  localparam int          CDRI_COND_W     = 2;
  localparam int          CDRI_ADDR_W     = 32;
  localparam int          CDRI_DATA_W     = 32;
  localparam int          CDRI_CTRL_W     = 4;
  localparam logic        CDRI_RST_ACK    = 1'b0;
  localparam logic        CDRI_RST_BUF    = 1'b0;
  typedef enum logic [1:0] {CDRI_RUN, CDRI_WAIT_DONE, CDRI_HALTED} cdri_state_t;
endpackage

/* File: logic/cdri_watch_unit.sv */
`timescale 1ns/10ps
module cdri_watch_unit
  import cdri_pkg::*;
#(
  parameter int AW = CDRI_ADDR_W,
  parameter int DW = CDRI_DATA_W,
  parameter int CW = CDRI_CTRL_W,
  parameter int XW = CDRI_COND_W
)(
  input  wire logic [AW-1:0] addr,        // bus address
  input  wire logic [DW-1:0] data,        // bus data
  input  wire logic [CW-1:0] ctrl,        // bus control
  input  wire logic [XW-1:0] cond,        // external condition
  input  wire logic [AW-1:0] addr_val,    // compare address
  input  wire logic [AW-1:0] addr_mask,   // 1 = don't care
  input  wire logic [DW-1:0] data_val,    // compare data
  input  wire logic [DW-1:0] data_mask,   // 1 = don't care
  input  wire logic [CW-1:0] ctrl_val,    // compare control
  input  wire logic [CW-1:0] ctrl_mask,   // 1 = don't care
  input  wire logic [XW-1:0] cond_val,    // compare condition
  input  wire logic [XW-1:0] cond_mask,   // 1 = don't care
  output logic               match        // raw comparator match
);
  wire a_ok = &((addr ~^ addr_val) | addr_mask);
  wire d_ok = &((data ~^ data_val) | data_mask);
  wire c_ok = &((ctrl ~^ ctrl_val) | ctrl_mask);
  wire x_ok = &((cond ~^ cond_val) | cond_mask);
  assign match = a_ok & d_ok & c_ok & x_ok;
endmodule // cdri_watch_unit

/* File: logic/cdri_core_debug.sv */
`timescale 1ns/10ps
module cdri_core_debug
  import cdri_pkg::*;
#(
  parameter int NW = CDRI_NUM_WATCH,
  parameter int AW = CDRI_ADDR_W,
  parameter int DW = CDRI_DATA_W,
  parameter int CW = CDRI_CTRL_W,
  parameter int XW = CDRI_COND_W
)(
  input  wire logic             clk,                   // core clock
  input  wire logic             reset,                 // sync, active high
  input  wire logic             debug_enable_in,       // static debug enable
  input  wire logic             ext_breakpoint_in,     // external breakpoint
  input  wire logic             ext_debug_request_in,  // external debug request
  input  wire logic [XW-1:0]    ext_condition_in,      // external condition
  input  wire logic             mem_access,            // access valid this cycle
  input  wire logic             mem_is_fetch,          // access is a fetch
  input  wire logic [AW-1:0]    bus_addr,              // access address
  input  wire logic [DW-1:0]    bus_data,              // access data
  input  wire logic [CW-1:0]    bus_ctrl,              // access control
  input  wire logic             exec_marked,           // marked fetch now executes
  input  wire logic             fetch_flushed,         // marked fetch discarded
  input  wire logic             instr_done,            // current instruction retires
  input  wire logic             debug_exit,            // restart from debug state
  input  wire logic [NW*AW-1:0] wp_addr_val,           // watch address values
  input  wire logic [NW*AW-1:0] wp_addr_mask,          // watch address masks
  input  wire logic [NW*DW-1:0] wp_data_val,           // watch data values
  input  wire logic [NW*DW-1:0] wp_data_mask,          // watch data masks
  input  wire logic [NW*CW-1:0] wp_ctrl_val,           // watch control values
  input  wire logic [NW*CW-1:0] wp_ctrl_mask,          // watch control masks
  input  wire logic [NW*XW-1:0] wp_cond_val,           // watch condition values
  input  wire logic [NW*XW-1:0] wp_cond_mask,          // watch condition masks
  input  wire logic [NW-1:0]    wp_enable,             // watch enable bits
  input  wire logic             rx_write,              // debugger fills rx buffer
  input  wire logic             rx_read,               // core reads rx buffer
  input  wire logic             tx_write,              // core fills tx buffer
  input  wire logic             tx_read,               // debugger drains tx buffer
  output logic                  access_breakpointed,   // current access marked
  output logic                  fetch_mark_pending,    // marked fetch in flight
  output logic                  watch_hit,             // enabled watch matched
  output logic                  debug_ack_out,         // in debug state
  output logic [NW-1:0]         watch_range_match_out, // raw watch matches
  output logic                  comms_rx_full,         // rx buffer holds data
  output logic                  comms_tx_empty         // tx buffer empty
);
  cdri_state_t state;
  cdri_state_t next_state;
  logic        fetch_mark;
  logic        next_fetch_mark;
  logic        rx_full;
  logic        tx_full;
  logic [NW-1:0] raw_match;

  genvar g;
  generate
    for (g = 0; g < NW; g++)
    begin : g_watch
      cdri_watch_unit #(.AW(AW), .DW(DW), .CW(CW), .XW(XW)) u_watch (
        .addr      (bus_addr),
        .data      (bus_data),
        .ctrl      (bus_ctrl),
        .cond      (ext_condition_in),
        .addr_val  (wp_addr_val[g*AW +: AW]),
        .addr_mask (wp_addr_mask[g*AW +: AW]),
        .data_val  (wp_data_val[g*DW +: DW]),
        .data_mask (wp_data_mask[g*DW +: DW]),
        .ctrl_val  (wp_ctrl_val[g*CW +: CW]),
        .ctrl_mask (wp_ctrl_mask[g*CW +: CW]),
        .cond_val  (wp_cond_val[g*XW +: XW]),
        .cond_mask (wp_cond_mask[g*XW +: XW]),
        .match     (raw_match[g])
      );
    end
  endgenerate

  // enable gates only the halt path, never the range outputs
  wire dbg_on    = debug_enable_in;
  wire bp_mark   = dbg_on & mem_access & ext_breakpoint_in;
  wire bp_fetch  = bp_mark & mem_is_fetch;
  wire bp_data   = bp_mark & ~mem_is_fetch;
  wire wp_fire   = dbg_on & mem_access & ~mem_is_fetch & |(raw_match & wp_enable);
  wire req_fire  = dbg_on & ext_debug_request_in;
  wire halt_now  = dbg_on & (fetch_mark | bp_fetch) & exec_marked;
  wire want_done = bp_data | wp_fire | req_fire;

  assign access_breakpointed = bp_mark;
  assign watch_hit           = wp_fire;
  assign fetch_mark_pending  = fetch_mark;

  always_comb
  begin
    next_state      = state;
    next_fetch_mark = fetch_mark;
    // a new marked fetch outranks the flush of an older one
    if (fetch_flushed & ~halt_now)
      next_fetch_mark = 1'b0;
    if (bp_fetch)
      next_fetch_mark = 1'b1;
    case (state)
      CDRI_RUN:
      begin
        if (halt_now)
          next_state = CDRI_HALTED;
        else if (want_done & instr_done)
          next_state = CDRI_HALTED;
        else if (want_done)
          next_state = CDRI_WAIT_DONE;
      end
      CDRI_WAIT_DONE:
      begin
        if (halt_now | instr_done)
          next_state = CDRI_HALTED;
      end
      CDRI_HALTED:
      begin
        next_fetch_mark = 1'b0;
        if (debug_exit)
          next_state = CDRI_RUN;
      end
      default:
        next_state = CDRI_RUN;
    endcase
    if (!dbg_on)
    begin
      next_state      = CDRI_RUN;
      next_fetch_mark = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state      <= CDRI_RUN;
      fetch_mark <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      fetch_mark <= next_fetch_mark;
    end
  end

  // write wins over read in the same cycle so no word is lost
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_full <= CDRI_RST_BUF;
      tx_full <= CDRI_RST_BUF;
    end
    else
    begin
      rx_full <= rx_write | (rx_full & ~rx_read);
      tx_full <= tx_write | (tx_full & ~tx_read);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      debug_ack_out         <= CDRI_RST_ACK;
      watch_range_match_out <= '0;
    end
    else
    begin
      debug_ack_out         <= (next_state == CDRI_HALTED);
      watch_range_match_out <= raw_match;
    end
  end

  assign comms_rx_full  = rx_full;
  assign comms_tx_empty = ~tx_full;

  // ack must stand until an exit or a disable releases it
  property p_ack_state;
    @(posedge clk) disable iff (reset)
    (debug_ack_out && !debug_exit && debug_enable_in) |=> debug_ack_out;
  endproperty
  a_ack_state: assert property (p_ack_state) else $error("ack disagrees with state");

  property p_disabled_no_ack;
    @(posedge clk) disable iff (reset)
    !debug_enable_in |=> !debug_ack_out;
  endproperty
  a_disabled_no_ack: assert property (p_disabled_no_ack) else $error("ack while disabled");

  property p_req_halts;
    @(posedge clk) disable iff (reset)
    (state == CDRI_RUN && req_fire && instr_done && !debug_exit) |=> debug_ack_out;
  endproperty
  a_req_halts: assert property (p_req_halts) else $error("request not honoured");

  property p_data_bp_waits;
    @(posedge clk) disable iff (reset)
    (state == CDRI_RUN && bp_data && !instr_done && !halt_now && debug_enable_in)
      |=> (state == CDRI_WAIT_DONE);
  endproperty
  a_data_bp_waits: assert property (p_data_bp_waits) else $error("data break not held");

  property p_wait_completes;
    @(posedge clk) disable iff (reset)
    (state == CDRI_WAIT_DONE && instr_done && debug_enable_in) |=> debug_ack_out;
  endproperty
  a_wait_completes: assert property (p_wait_completes) else $error("no halt at completion");

  property p_fetch_exec;
    @(posedge clk) disable iff (reset)
    (fetch_mark && exec_marked && debug_enable_in && state != CDRI_HALTED) |=> debug_ack_out;
  endproperty
  a_fetch_exec: assert property (p_fetch_exec) else $error("marked fetch did not halt");

  property p_flush_clears;
    @(posedge clk) disable iff (reset)
    (fetch_flushed && !exec_marked && !bp_fetch) |=> !fetch_mark;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("flushed fetch still marked");

  property p_fetch_marks;
    @(posedge clk) disable iff (reset)
    (bp_fetch && state != CDRI_HALTED) |=> fetch_mark;
  endproperty
  a_fetch_marks: assert property (p_fetch_marks) else $error("marked fetch not held");

  property p_rx_flag;
    @(posedge clk) disable iff (reset)
    rx_write |=> comms_rx_full;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("rx full not set");

  property p_tx_flag;
    @(posedge clk) disable iff (reset)
    (tx_read && !tx_write) |=> comms_tx_empty;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx empty not set");

  property p_range_raw;
    @(posedge clk) disable iff (reset)
    watch_range_match_out == ($past(reset) ? {NW{1'b0}} : $past(raw_match));
  endproperty
  a_range_raw: assert property (p_range_raw) else $error("range not raw match");

  property p_mark_needs_input;
    @(posedge clk) disable iff (reset)
    access_breakpointed |-> (ext_breakpoint_in && mem_access && debug_enable_in);
  endproperty
  a_mark_needs_input: assert property (p_mark_needs_input) else $error("bad mark");
endmodule // cdri_core_debug

/* File: testbench/cdri_debug_host.sv */
`timescale 1ns/10ps
module cdri_debug_host (
  input  wire logic clk,                  // core clock
  input  wire logic reset,                // sync, active high
  input  wire logic start,                // bench asks for a halt
  input  wire logic debug_ack_out,        // device in debug state
  output logic      ext_debug_request_in  // request to the device
);
  logic pend;

  // idle low, the same level an unused request is tied to
  always_ff @(posedge clk)
    if (reset || debug_ack_out)
      pend <= 1'b0;
    else if (start)
      pend <= 1'b1;

  // dropped combinationally so it is gone in the very cycle ack rises
  assign ext_debug_request_in = pend & ~debug_ack_out;
endmodule // cdri_debug_host

/* File: testbench/cdri_core_debug_test.sv */
`timescale 1ns/10ps
module cdri_core_debug_test
  import cdri_pkg::*;
;
  localparam int NW = CDRI_NUM_WATCH, AW = CDRI_ADDR_W, DW = CDRI_DATA_W;
  localparam int CW = CDRI_CTRL_W, XW = CDRI_COND_W;
  logic clk = 0, reset = 1, debug_enable_in = 1, ext_breakpoint_in = 0, host_go = 0;
  logic ext_debug_request_in, mem_access = 0, mem_is_fetch = 0, exec_marked = 0;
  logic fetch_flushed = 0, instr_done = 0, debug_exit = 0;
  logic rx_write = 0, rx_read = 0, tx_write = 0, tx_read = 0;
  logic [XW-1:0]    ext_condition_in = '0;
  logic [AW-1:0]    bus_addr = '0;
  logic [DW-1:0]    bus_data = '0;
  logic [CW-1:0]    bus_ctrl = '0;
  logic [NW*AW-1:0] wp_addr_val = '0, wp_addr_mask = '0;
  logic [NW*DW-1:0] wp_data_val = '0, wp_data_mask = '0;
  logic [NW*CW-1:0] wp_ctrl_val = '0, wp_ctrl_mask = '0;
  logic [NW*XW-1:0] wp_cond_val = '0, wp_cond_mask = '0;
  logic [NW-1:0]    wp_enable = '0, watch_range_match_out, e;
  logic access_breakpointed, fetch_mark_pending, watch_hit, debug_ack_out;
  logic comms_rx_full, comms_tx_empty;
  int   err_count = 0, total_checks = 0, seed = 32'h22bd;

  always #5 clk = ~clk;

  cdri_core_debug dut (.*);
  cdri_debug_host host (.clk, .reset, .start(host_go), .debug_ack_out, .ext_debug_request_in);

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask

  task automatic mark(input logic f, input logic exp);
    mem_access = 1;
    mem_is_fetch = f;
    ext_breakpoint_in = 1;
    #1 chk("marked", exp, access_breakpointed);
    tick();
    mem_access = 0;
    ext_breakpoint_in = 0;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // differs from v only under the mask when h is set, anywhere otherwise
  function automatic logic [31:0] near(input logic [31:0] v, m, input logic h);
    return v ^ ($random(seed) & (h ? m : 32'hffff_ffff));
  endfunction

  function automatic logic [NW-1:0] exp_rng();
    logic [NW-1:0] m;
    for (int g = 0; g < NW; g++)
      m[g] = (((bus_addr ^ wp_addr_val[g*AW +: AW]) & ~wp_addr_mask[g*AW +: AW]) == 0)
        && (((bus_data ^ wp_data_val[g*DW +: DW]) & ~wp_data_mask[g*DW +: DW]) == 0)
        && (((bus_ctrl ^ wp_ctrl_val[g*CW +: CW]) & ~wp_ctrl_mask[g*CW +: CW]) == 0)
        && (((ext_condition_in ^ wp_cond_val[g*XW +: XW]) & ~wp_cond_mask[g*XW +: XW]) == 0);
    return m;
  endfunction

  initial
  begin
    logic h;
    tick(3);
    reset = 0;
    chk("ack", 0, debug_ack_out);
    chk("range", 0, watch_range_match_out);
    chk("rx_full", 0, comms_rx_full);
    chk("tx_empty", 1, comms_tx_empty);
    rx_read = 1;
    pulse(rx_write);
    chk("rx_full", 1, comms_rx_full);
    pulse(rx_read);
    chk("rx_full", 0, comms_rx_full);
    pulse(tx_write);
    tick(2);
    chk("tx_empty", 0, comms_tx_empty);
    pulse(tx_read);
    chk("tx_empty", 1, comms_tx_empty);
    pulse(host_go);
    tick(3);
    chk("ack", 0, debug_ack_out);
    pulse(instr_done);
    chk("ack", 1, debug_ack_out);
    tick(3);
    chk("ack", 1, debug_ack_out);
    pulse(debug_exit);
    chk("ack", 0, debug_ack_out);
    mark(0, 1);
    chk("ack", 0, debug_ack_out);
    pulse(instr_done);
    chk("ack", 1, debug_ack_out);
    pulse(debug_exit);
    mark(1, 1);
    chk("pending", 1, fetch_mark_pending);
    pulse(fetch_flushed);
    pulse(instr_done);
    chk("ack", 0, debug_ack_out);
    mark(1, 1);
    pulse(exec_marked);
    chk("ack", 1, debug_ack_out);
    pulse(debug_exit);
    debug_enable_in = 0;
    pulse(host_go);
    mark(0, 0);
    pulse(instr_done);
    chk("ack", 0, debug_ack_out);
    debug_enable_in = 1;
    pulse(instr_done);
    chk("ack", 1, debug_ack_out);
    debug_enable_in = 0;
    tick();
    chk("ack", 0, debug_ack_out);
    debug_enable_in = 1;
    wp_addr_mask = '1;
    wp_data_mask = '1;
    wp_ctrl_mask = '1;
    wp_cond_mask = '1;
    wp_enable = 2'b01;
    mem_access = 1;
    #1 chk("watch_hit", 1, watch_hit);
    tick();
    mem_access = 0;
    wp_enable = 0;
    pulse(instr_done);
    chk("ack", 1, debug_ack_out);
    pulse(debug_exit);
    // halts are off the table here: no access is presented
    repeat (40)
    begin
      bus_addr = $random(seed);
      bus_data = $random(seed);
      bus_ctrl = CW'($random(seed));
      ext_condition_in = XW'($random(seed));
      wp_enable = NW'($random(seed));
      debug_enable_in = 1'($random(seed));
      for (int g = 0; g < NW; g++)
      begin
        h = 1'($random(seed));
        wp_addr_mask[g*AW +: AW] = $random(seed);
        wp_data_mask[g*DW +: DW] = $random(seed);
        wp_ctrl_mask[g*CW +: CW] = CW'($random(seed));
        wp_cond_mask[g*XW +: XW] = XW'($random(seed));
        wp_addr_val[g*AW +: AW] = near(bus_addr, wp_addr_mask[g*AW +: AW], h);
        wp_data_val[g*DW +: DW] = near(bus_data, wp_data_mask[g*DW +: DW], h);
        wp_ctrl_val[g*CW +: CW] = CW'(near(32'(bus_ctrl), 32'(wp_ctrl_mask[g*CW +: CW]), h));
        wp_cond_val[g*XW +: XW] =
          XW'(near(32'(ext_condition_in), 32'(wp_cond_mask[g*XW +: XW]), h));
      end
      e = exp_rng();
      tick();
      chk("range", e, watch_range_match_out);
    end
    final_report();
  end

  // the whole sequence needs well under 200 cycles
  initial
  begin
    #20us;
    err_count++;
    final_report();
  end
endmodule // cdri_core_debug_test
